// file: pkg/usf_pkg.sv
// What this block does
// - Status may be read anytime; the snapshot holds still during a status read.
// - Transmit-ready status bit equals transmit buffer empty, nothing more.
// - Transmit-ready pin needs buffer empty, clear-to-send low and transmit enable.
// - Receive-ready sets while an assembled character waits in the receive buffer.
// - Transmitter-empty bit sets whenever the transmit shifter holds no character.
// - Parity fault sets when a loaded character has wrong count of ones.
// - Overrun fault sets when a new character replaces an unread one.
// - Framing fault sets, asynchronous mode only, when the stop bit samples low.
// - Set fault flags never stop or alter receiver or transmitter operation.
// - Fault flags clear by fault flush command, soft reset command or reset input.
// - Fault flush clears all faults even with receive gate bit zero.
// - Sync-found bit clears on each status read, unless internal sync hits or the sampled external sync level is high.
// - Each status bit follows its condition within 16 clock periods.
// - Receive gate low only hides receive-ready; reception and loading carry on.
// - External sync selected disables internal detection; only external shows.
// - External sync status is a flop, high while input high, cleared by read.
// - Data-set-ready status bit follows the modem data-set-ready input.
// - Command bit 0 enables transmission, together with active clear-to-send.
// - Command bit 2 gates generation of receive-ready.
// - Command bit 4 is a momentary fault flush, never latched.
// - Command bit 7 starts hunt in sync mode only: stop assembling, fill ones, seek sync, no parity.
package usf_pkg;
  localparam logic [1:0] ADDR_STATUS   = 2'h0;
  localparam logic [1:0] ADDR_CMD      = 2'h1;
  localparam logic [1:0] ADDR_MODE     = 2'h2;
  localparam int         CMD_TX_ALLOW  = 0;
  localparam int         CMD_RX_GATE   = 2;
  localparam int         CMD_FLUSH     = 4;
  localparam int         CMD_SOFT_RST  = 6;
  localparam int         CMD_HUNT      = 7;
  localparam int         MODE_ASYNC    = 0;
  localparam int         MODE_EXT_SYNC = 1;
  localparam logic [7:0] CMD_RST       = 8'h00;
  localparam logic [7:0] MODE_RST      = 8'h01;
  localparam logic [7:0] STAT_RST      = 8'h00;
  localparam int         STAT_MAX_TCY  = 16;
  localparam int         PIN_CTS_N     = 0;
  localparam int         PIN_DSR_N     = 1;
  localparam int         PIN_EXT_SYNC  = 2;
  localparam int         PIN_RX_CLK    = 3;
  localparam logic [3:0] PIN_RST       = 4'h3;

  typedef struct packed {
    logic dsr_ready;
    logic sync_found_flag;
    logic framing_fault;
    logic overrun_fault;
    logic parity_fault;
    logic tx_shifter_empty;
    logic rx_char_waiting;
    logic tx_buf_ready;
  } usf_stat_t;

  typedef struct packed {
    logic load;
    logic parity_bad;
    logic stop_bit;
    logic sync_hit;
  } usf_rx_evt_t;

  typedef enum logic {HS_IDLE, HS_HUNT} usf_hunt_t;
endpackage

// file: src/usf_status.sv
`timescale 1ns/1ps
module usf_status
  import usf_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        tx_buf_empty,
  input  wire logic        tx_shift_empty,
  input  wire usf_rx_evt_t rx_evt,
  input  wire logic        rx_data_read,
  input  wire logic        cts_n_pin,
  input  wire logic        dsr_n_pin,
  input  wire logic        ext_sync_pin,
  input  wire logic        rx_clk_pin,
  output logic             tx_ready_pin,
  output logic             rx_ready_pin,
  output logic             tx_allow_bit,
  output logic             hunt_active,
  output logic             soft_reset_pulse
);

  function automatic logic pin_next(input logic s2, input logic s3, input logic cur);
    pin_next = (s2 == s3) ? s3 : cur;
  endfunction

  logic      [3:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_f_q;
  logic      [3:0] pin_f_d;
  logic      [7:0] cmd_q, mode_q;
  usf_stat_t       stat_q, stat_d;
  usf_hunt_t       hunt_q, hunt_d;
  logic            rx_full_q, par_q, ovr_q, frm_q, sync_q, ext_lvl_q, rxc_old_q;
  logic            soft_q, txr_q, rxr_q;
  logic      [7:0] rdata_q;

  // Pin filter: stage 2 and 3 must agree
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_f_d[i] = pin_next(pin_s2_q[i], pin_s3_q[i], pin_f_q[i]);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_q <= PIN_RST;
      pin_s2_q <= PIN_RST;
      pin_s3_q <= PIN_RST;
      pin_f_q  <= PIN_RST;
    end else if (clk_en) begin
      pin_s1_q <= {rx_clk_pin, ext_sync_pin, dsr_n_pin, cts_n_pin};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_f_q  <= pin_f_d;
    end
  end

  wire cts_act   = ~pin_f_q[PIN_CTS_N];
  wire dsr_act   = ~pin_f_q[PIN_DSR_N];
  wire rxc_fall  = rxc_old_q & ~pin_f_q[PIN_RX_CLK];

  // Bus decode
  wire cmd_wr    = reg_wr & (reg_addr == ADDR_CMD);
  wire mode_wr   = reg_wr & (reg_addr == ADDR_MODE);
  wire stat_rd   = reg_rd & (reg_addr == ADDR_STATUS);
  wire soft_rst  = cmd_wr & reg_wdata[CMD_SOFT_RST];
  wire flush     = cmd_wr & reg_wdata[CMD_FLUSH];
  wire fault_clr = flush | soft_rst;
  wire async_m   = mode_q[MODE_ASYNC];
  wire ext_m     = mode_q[MODE_EXT_SYNC];
  wire rx_gate   = cmd_q[CMD_RX_GATE];
  wire hunting   = (hunt_q == HS_HUNT);
  // Hunt stops assembling, so no loads count
  wire ld        = rx_evt.load & ~hunting;
  // Internal detection off under external sync
  wire int_hit   = rx_evt.sync_hit & ~async_m & ~ext_m;
  wire cmd_hunt  = cmd_wr & reg_wdata[CMD_HUNT] & ~async_m & ~soft_rst;

  // Receive buffer full, set wins over read
  wire rx_full_d = ld | (rx_full_q & ~rx_data_read & ~soft_rst);
  wire par_d     = (ld & rx_evt.parity_bad) | (par_q & ~fault_clr);
  wire ovr_d     = (ld & rx_full_q & ~rx_data_read) | (ovr_q & ~fault_clr);
  wire frm_d     = (ld & async_m & ~rx_evt.stop_bit) | (frm_q & ~fault_clr);
  // External level held, read clears once input gone
  wire ext_lvl_d = rxc_fall ? pin_f_q[PIN_EXT_SYNC] : ext_lvl_q;
  // Sync flag clears on status read, set wins
  wire sync_set  = ext_m ? ext_lvl_q : int_hit;
  wire sync_d    = ~async_m & (sync_set | (sync_q & ~stat_rd & ~soft_rst));

  // Hunt sequencing
  always_comb begin
    hunt_d = hunt_q;
    case (hunt_q)
      HS_IDLE: begin
        if (cmd_hunt) begin
          hunt_d = HS_HUNT;
        end
      end
      HS_HUNT: begin
        if (soft_rst || int_hit || (cmd_wr && !cmd_hunt)) begin
          hunt_d = HS_IDLE;
        end
      end
      default: begin
        hunt_d = HS_IDLE;
      end
    endcase
  end

  // Status lags its flag by one cycle
  // Live status word assembly
  always_comb begin
    stat_d                  = stat_q;
    // Snapshot frozen during a status read
    if (!stat_rd) begin
      // Status bit is buffer empty only
      stat_d.tx_buf_ready     = tx_buf_empty;
      // Gate hides the flag, buffer still loads
      stat_d.rx_char_waiting  = rx_full_q & rx_gate;
      stat_d.tx_shifter_empty = tx_shift_empty;
      stat_d.parity_fault     = par_q;
      stat_d.overrun_fault    = ovr_q;
      stat_d.framing_fault    = frm_q;
      stat_d.sync_found_flag  = sync_q;
      stat_d.dsr_ready        = dsr_act;
    end
  end

  wire [7:0] rd_mux = (reg_addr == ADDR_STATUS) ? stat_q :
                      (reg_addr == ADDR_CMD)    ? cmd_q  :
                      (reg_addr == ADDR_MODE)   ? mode_q : 8'h00;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_q  <= CMD_RST;
      mode_q <= MODE_RST;
    end else if (clk_en) begin
      if (soft_rst) begin
        cmd_q <= CMD_RST;
      end else if (cmd_wr) begin
        cmd_q <= reg_wdata & ~(8'h01 << CMD_FLUSH) & ~(8'h01 << CMD_SOFT_RST);
      end
      if (mode_wr) begin
        mode_q <= reg_wdata;
      end
    end
  end

  // Fault flags feed nothing but status
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_full_q <= 1'b0;
      par_q     <= 1'b0;
      ovr_q     <= 1'b0;
      frm_q     <= 1'b0;
      sync_q    <= 1'b0;
      ext_lvl_q <= 1'b0;
      rxc_old_q <= 1'b0;
      hunt_q    <= HS_IDLE;
      stat_q    <= STAT_RST;
    end else if (clk_en) begin
      rx_full_q <= rx_full_d;
      par_q     <= par_d;
      ovr_q     <= ovr_d;
      frm_q     <= frm_d;
      sync_q    <= sync_d;
      ext_lvl_q <= ext_lvl_d;
      rxc_old_q <= pin_f_q[PIN_RX_CLK];
      hunt_q    <= hunt_d;
      stat_q    <= stat_d;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
      soft_q  <= 1'b0;
      txr_q   <= 1'b0;
      rxr_q   <= 1'b0;
    end else if (clk_en) begin
      rdata_q <= reg_rd ? rd_mux : 8'h00;
      soft_q  <= soft_rst;
      // Pin gated by clear-to-send and enable
      txr_q   <= tx_buf_empty & cts_act & cmd_q[CMD_TX_ALLOW];
      rxr_q   <= rx_full_q & rx_gate;
    end
  end

  assign reg_rdata        = rdata_q;
  assign tx_ready_pin     = txr_q;
  assign rx_ready_pin     = rxr_q;
  assign tx_allow_bit     = cmd_q[CMD_TX_ALLOW];
  assign hunt_active      = (hunt_q == HS_HUNT);
  assign soft_reset_pulse = soft_q;

  localparam int ST_WIN = STAT_MAX_TCY;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn || !clk_en);

  sequence s_status_read;
    stat_rd;
  endsequence

  sequence s_flush_cmd;
    cmd_wr && reg_wdata[CMD_FLUSH] && !reg_wdata[CMD_RX_GATE];
  endsequence

  frozen_on_read_a: assert property (s_status_read |=> $stable(stat_q))
    else $error("status changed during status read");
  tx_stat_equal_a: assert property (!stat_rd |=> stat_q.tx_buf_ready == $past(tx_buf_empty))
    else $error("tx ready status not buffer empty");
  tx_pin_gate_a: assert property (tx_ready_pin |-> $past(tx_buf_empty) && $past(cts_act) && $past(tx_allow_bit))
    else $error("tx ready pin without all conditions");
  rx_load_flag_a: assert property (ld |=> rx_full_q)
    else $error("loaded character not flagged");
  txe_follow_a: assert property ($changed(tx_shift_empty) |-> ##[1:ST_WIN] stat_q.tx_shifter_empty == tx_shift_empty)
    else $error("tx empty status late");
  parity_set_a: assert property (ld && rx_evt.parity_bad |=> par_q)
    else $error("parity fault missed");
  overrun_set_a: assert property (ld && rx_full_q && !rx_data_read |=> ovr_q)
    else $error("overrun missed");
  framing_async_a: assert property (frm_q && !$past(frm_q) |-> $past(async_m) && !$past(rx_evt.stop_bit))
    else $error("framing fault without async bad stop");
  flush_clears_a: assert property (s_flush_cmd ##0 !ld |=> !par_q && !ovr_q && !frm_q)
    else $error("flush left a fault set");
  sync_read_clr_a: assert property (s_status_read ##0 !sync_set |=> !sync_q)
    else $error("sync flag survived status read");
  gate_hides_a: assert property (!rx_gate |=> !rx_ready_pin)
    else $error("receive ready shown while gated");
  ext_only_a: assert property (ext_m && rx_evt.sync_hit && !ext_lvl_q && !sync_q |=> !sync_q)
    else $error("internal sync under external mode");
  dsr_follow_a: assert property (!stat_rd |=> stat_q.dsr_ready == $past(dsr_act))
    else $error("modem ready status wrong");

endmodule // usf_status

// file: tb/usf_far_model.sv
`timescale 1ns/1ps
module usf_far_model (
  input  wire logic link_run,
  input  wire logic ext_lvl,
  output logic      rx_clk_pin,
  output logic      ext_sync_pin
);
  // Link clock runs only within a frame, 64 ns period
  initial begin
    rx_clk_pin = 1'b0;
    #5;
    forever begin
      #32;
      rx_clk_pin = link_run ? ~rx_clk_pin : 1'b0;
    end
  end
  // Sync level stable at falling edges
  initial ext_sync_pin = 1'b0;
  always @(posedge rx_clk_pin) ext_sync_pin <= ext_lvl;
endmodule // usf_far_model

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import usf_pkg::*;
  logic        clk, resetn, reg_wr, reg_rd, tx_be, tx_se, rx_rd, cts_n, dsr_n, link_run, ext_lvl;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, v;
  usf_rx_evt_t rx_evt;
  logic        rx_clk_pin, ext_sync_pin, tx_ready_pin, rx_ready_pin, hunt_active, tx_allow, soft_pulse;
  int          n_fail, compares;

  usf_status usf_status_i (.clk(clk), .resetn(resetn), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_buf_empty(tx_be), .tx_shift_empty(tx_se), .rx_evt(rx_evt), .rx_data_read(rx_rd),
    .cts_n_pin(cts_n), .dsr_n_pin(dsr_n), .ext_sync_pin(ext_sync_pin), .rx_clk_pin(rx_clk_pin),
    .tx_ready_pin(tx_ready_pin), .rx_ready_pin(rx_ready_pin), .tx_allow_bit(tx_allow),
    .hunt_active(hunt_active), .soft_reset_pulse(soft_pulse));
  usf_far_model usf_far_model_i (.link_run(link_run), .ext_lvl(ext_lvl),
    .rx_clk_pin(rx_clk_pin), .ext_sync_pin(ext_sync_pin));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic evt(input logic [3:0] e);
    @(posedge clk);
    rx_evt <= usf_rx_evt_t'(e);
    @(posedge clk);
    rx_evt <= usf_rx_evt_t'(4'h0);
  endtask
  task automatic data_read();
    @(posedge clk);
    rx_rd <= 1'b1;
    @(posedge clk);
    rx_rd <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic t_regs();
    rd(2'h0, v); chk(v, 8'h85);
    rd(2'h1, v); chk(v, 8'h00);
    rd(2'h2, v); chk(v, 8'h01);
    rd(2'h3, v); chk(v, 8'h00);
  endtask
  task automatic t_tx();
    wr(2'h1, 8'h01); settle(16); chk(tx_ready_pin, 1'b1);
    chk(tx_allow, 1'b1);
    cts_n <= 1'b1; settle(16); chk(tx_ready_pin, 1'b0);
    cts_n <= 1'b0; tx_be <= 1'b0; tx_se <= 1'b0; dsr_n <= 1'b1; settle(16);
    chk(tx_ready_pin, 1'b0);
    rd(2'h0, v); chk(v, 8'h00);
    tx_be <= 1'b1; tx_se <= 1'b1; dsr_n <= 1'b0; settle(16);
    rd(2'h0, v); chk(v, 8'h85);
  endtask
  task automatic t_rx();
    // Fault flush sent with receive gate
    wr(2'h1, 8'h14);
    data_read();
    evt(4'hC); settle(16); chk(rx_ready_pin, 1'b1);
    rd(2'h0, v); chk(v, 8'hAF);
    evt(4'hA); settle(16); rd(2'h0, v); chk(v, 8'hBF);
    wr(2'h1, 8'h10); settle(16); chk(rx_ready_pin, 1'b0);
    rd(2'h0, v); chk(v, 8'h85);
    rd(2'h1, v); chk(v, 8'h00);
    wr(2'h1, 8'h04); settle(16); rd(2'h0, v); chk(v, 8'h87);
    data_read(); settle(16); rd(2'h0, v); chk(v, 8'h85);
    evt(4'hC); wr(2'h1, 8'h40);
    #1 chk(soft_pulse, 1'b1);
    settle(16); rd(2'h0, v); chk(v, 8'h85);
    chk(tx_allow, 1'b0);
  endtask
  task automatic t_sync();
    wr(2'h2, 8'h00); evt(4'h8); data_read(); settle(16);
    wr(2'h1, 8'h04); settle(16); rd(2'h0, v); chk(v, 8'h85);
    wr(2'h1, 8'h80); settle(4); chk(hunt_active, 1'b1);
    evt(4'h1); settle(16); chk(hunt_active, 1'b0);
    rd(2'h0, v); chk(v, 8'hC5);
    rd(2'h0, v); chk(v, 8'h85);
  endtask
  task automatic t_ext();
    wr(2'h2, 8'h02); link_run <= 1'b1; ext_lvl <= 1'b1; settle(40);
    rd(2'h0, v); chk(v, 8'hC5);
    rd(2'h0, v); chk(v, 8'hC5);
    ext_lvl <= 1'b0; settle(40); rd(2'h0, v); settle(16);
    rd(2'h0, v); chk(v, 8'h85);
    evt(4'h1); settle(16); rd(2'h0, v); chk(v, 8'h85);
    link_run <= 1'b0;
  endtask

  initial begin
    n_fail = 0; compares = 0; resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 2'h0;
    reg_wdata = 8'h00; rx_evt = usf_rx_evt_t'(4'h0); rx_rd = 1'b0; tx_be = 1'b1; tx_se = 1'b1;
    cts_n = 1'b0; dsr_n = 1'b0; link_run = 1'b0; ext_lvl = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    settle(16);
    data_read();
    t_regs();
    t_tx();
    t_rx();
    t_sync();
    t_ext();
    wrap_up();
  end
  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end
endmodule // tb
